// ==== logic/edge_alarm_defines.svh ====
// Shared constants for the edge process alarm device end and controller end.
// Assumes inclusion by bare name from files compiled in the logic folder.
`ifndef EDGE_ALARM_DEFINES_SVH
`define EDGE_ALARM_DEFINES_SVH

// Module shape
`define IN_BYTES 4
`define IN_BITS 32
`define INT_LINES 4
`define ADDR_W 8
`define BYTE_W 8
`define LAST_BYTE 2'h3

// Backplane addresses
`define ALARM_BYTE_ADDR 8'h00
`define MODULE_BASE_DEF 8'h80
`define MODULE_BASE_MIN 8'h80

// Controller APB register offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
`define REG_WORD_FIRST 8'h0c
`define REG_WORD_SECOND 8'h10

// Control register fields
`define CTRL_ENABLE 0
`define CTRL_BYTE_MODE 1
`define CTRL_LINE_LSB 2
`define CTRL_LINE_MSB 3
`define CTRL_BIT_LSB 8
`define CTRL_BIT_MSB 10
`define CTRL_W 11
`define CTRL_RESET 11'h000

// Status and mask fields
`define ST_DONE 0
`define ST_SEEN 1
`define ST_W 2
`define ST_RESET 2'h0
`define MASK_RESET 2'h0

`endif

// ==== logic/edge_alarm_pkg.sv ====
// Types shared by both ends of the edge process alarm link.
// Assumes nothing beyond a SystemVerilog compiler.
package edge_alarm_pkg;

  // Read sequence tracker in the device
  typedef enum logic [1:0] {
    SEQ_OPEN = 2'b00,
    SEQ_GOT0 = 2'b01,
    SEQ_GOT1 = 2'b10,
    SEQ_GOT2 = 2'b11
  } seq_state_t;

  // Alarm service engine in the controller
  typedef enum logic [1:0] {
    SVC_IDLE = 2'b00,
    SVC_POLL = 2'b01,
    SVC_READ = 2'b10
  } svc_state_t;

endpackage

// ==== logic/backplane_if.sv ====
// Backplane between the edge alarm module and the controller.
// Assumes both ends run on one clock; interrupt lines are active-low wired lines.
`timescale 1ns/1ps
`include "edge_alarm_defines.svh"

interface backplane_if;
  logic rd_req;
  logic [`ADDR_W-1:0] rd_addr;
  logic rd_ack;
  logic [`BYTE_W-1:0] rd_data;
  logic [`INT_LINES-1:0] int_line_oe;
  logic [`INT_LINES-1:0] int_line_n;

  // Open-drain lines: any pulling module drives the line low
  assign int_line_n = ~int_line_oe;

  modport dev (
    input rd_req,
    input rd_addr,
    output rd_ack,
    output rd_data,
    output int_line_oe
  );

  modport ctl (
    output rd_req,
    output rd_addr,
    input rd_ack,
    input rd_data,
    input int_line_n
  );
endinterface

// ==== logic/edge_alarm_dev.sv ====
// Device end: 32-input edge process alarm with interrupt-line or alarm-byte path.
// Assumes process inputs and switch settings are asynchronous pins,
// and that the backplane request holds until rd_ack on the pclk domain.
//
// Contract
// RULE1: Controller reads four bytes in ascending order.
// RULE2: Byte 0 read blocks, byte 3 unblocks inputs.
// RULE3: Module placed above 127, no image access.
// RULE4: No double read of bytes per service.
// RULE5: Jumper two open, one closed: line mode.
// RULE6: Drive only the single selected interrupt line.
// RULE7: Alarm outputs combine on a shared line.
// RULE8: Line mode ignores alarm byte bit switches.
// RULE9: Alarm on rising or falling edge per selection.
// RULE10: One polarity switch per input byte.
// RULE11: Byte mode sets bit in address zero.
// RULE12: No other input module at address zero.
// RULE13: Service routine acknowledges, cannot be interrupted.
// RULE14: Controller treats alarm as level triggered.
// RULE15: Byte mode reads words at 128, 130.
// RULE16: Cyclic program uses stored copies only.
// RULE17: Alarm held until ascending sequence completes.
// RULE18: Blocked inputs raise nothing, data stays frozen.
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "edge_alarm_defines.svh"

module edge_alarm_dev #(
  parameter int IN_BITS = `IN_BITS
) (
  input wire logic pclk,
  input wire logic presetn,
  backplane_if.dev bus,
  input wire logic [IN_BITS-1:0] process_inputs,
  input wire logic [`ADDR_W-1:0] module_base,
  input wire logic alarm_path_jumper_first,
  input wire logic alarm_path_jumper_second,
  input wire logic [`INT_LINES-1:0] interrupt_line_select_switches,
  input wire logic [`BYTE_W-1:0] alarm_byte_bit_select_switches,
  input wire logic [`IN_BYTES-1:0] edge_polarity_switches,
  output logic alarm_pending,
  output logic inputs_blocked,
  output logic [`IN_BYTES-1:0] alarm_source_bytes
);
  import edge_alarm_pkg::*;

  localparam int CFG_W = `ADDR_W + 2 + `INT_LINES + `BYTE_W + `IN_BYTES;
  localparam int SYNC_W = IN_BITS + CFG_W;

  logic [SYNC_W-1:0] sync_first;
  logic [SYNC_W-1:0] sync_second;
  logic [IN_BITS-1:0] prev_in;
  logic [IN_BITS-1:0] held_in;
  logic ack_r;
  logic [`BYTE_W-1:0] data_r;
  seq_state_t seq;
  seq_state_t next_seq;
  logic next_alarm;
  logic [`IN_BYTES-1:0] next_source;

  // All pins cross through two flops before any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_first <= '0;
      sync_second <= '0;
    end else begin
      sync_first <= {process_inputs, module_base, alarm_path_jumper_first, alarm_path_jumper_second,
                     interrupt_line_select_switches, alarm_byte_bit_select_switches,
                     edge_polarity_switches};
      sync_second <= sync_first;
    end
  end

  // Unpack the settled pin values
  wire [IN_BITS-1:0] live_in = sync_second[SYNC_W-1 -: IN_BITS];
  wire [`ADDR_W-1:0] base_s = sync_second[CFG_W-1 -: `ADDR_W];
  wire jumper_first_s = sync_second[CFG_W-`ADDR_W-1];
  wire jumper_second_s = sync_second[CFG_W-`ADDR_W-2];
  wire [`INT_LINES-1:0] line_sel_s = sync_second[`INT_LINES+`BYTE_W+`IN_BYTES-1 -: `INT_LINES];
  wire [`BYTE_W-1:0] bit_sel_s = sync_second[`BYTE_W+`IN_BYTES-1 -: `BYTE_W];
  wire [`IN_BYTES-1:0] rising_s = sync_second[`IN_BYTES-1:0];

  // Alarm path decode from the two jumpers
  // RULE5: line mode select
  wire mode_line = jumper_first_s & ~jumper_second_s;
  // RULE11: byte zero mode select
  wire mode_byte = jumper_first_s & jumper_second_s;
  wire mode_any = mode_line | mode_byte;

  // A line setting with none or several switches on drives nothing
  // Staying off on a bad setting keeps a shared line free for others
  wire line_sel_none = (line_sel_s == '0);
  wire line_sel_multi = ((line_sel_s & (line_sel_s - `INT_LINES'(1))) != '0);
  wire line_sel_one = ~line_sel_none & ~line_sel_multi;

  // Edge detection per input, polarity shared across a byte
  wire [IN_BITS-1:0] rise_ev = live_in & ~prev_in;
  wire [IN_BITS-1:0] fall_ev = ~live_in & prev_in;
  logic [IN_BITS-1:0] edge_ev;
  logic [`IN_BYTES-1:0] byte_ev;

  // Limitation: one polarity per byte, no mixed edges inside a byte
  // RULE9: pick rising or falling
  // RULE10: polarity per byte
  always_comb begin
    edge_ev = '0;
    byte_ev = '0;
    for (int b = 0; b < `IN_BYTES; b++) begin
      edge_ev[b*`BYTE_W +: `BYTE_W] = rising_s[b] ? rise_ev[b*`BYTE_W +: `BYTE_W]
                                                  : fall_ev[b*`BYTE_W +: `BYTE_W];
      byte_ev[b] = |edge_ev[b*`BYTE_W +: `BYTE_W];
    end
  end

  // Request decode against the module window and address zero
  // Address zero is shared bus space, answered only in byte mode
  wire [`ADDR_W-1:0] rel_addr = bus.rd_addr - base_s;
  wire in_window = (bus.rd_addr >= base_s) && (rel_addr < `ADDR_W'(`IN_BYTES));
  wire [1:0] byte_idx = rel_addr[1:0];
  wire byte0_hit = mode_byte && (bus.rd_addr == `ALARM_BYTE_ADDR) && !in_window;
  // Ack guard keeps one held request from being taken twice
  wire take = bus.rd_req & ~ack_r & (in_window | byte0_hit);
  wire take_window = take & in_window;

  // Read sequence tracker; an out-of-order read leaves the state alone, except byte 0, which restarts at SEQ_GOT0
  // RULE2: first byte blocks, fourth unblocks
  always_comb begin
    next_seq = seq;
    if (take_window) begin
      case (seq)
        SEQ_OPEN: begin
          if (byte_idx == 2'h0) next_seq = SEQ_GOT0;
        end
        SEQ_GOT0: begin
          if (byte_idx == 2'h1) next_seq = SEQ_GOT1;
          else if (byte_idx == 2'h0) next_seq = SEQ_GOT0;
        end
        SEQ_GOT1: begin
          if (byte_idx == 2'h2) next_seq = SEQ_GOT2;
          else if (byte_idx == 2'h0) next_seq = SEQ_GOT0;
        end
        SEQ_GOT2: begin
          if (byte_idx == `LAST_BYTE) next_seq = SEQ_OPEN;
          else if (byte_idx == 2'h0) next_seq = SEQ_GOT0;
        end
        default: begin
          next_seq = SEQ_OPEN;
        end
      endcase
    end
  end

  wire blocked = (seq != SEQ_OPEN);
  wire seq_done = take_window && (seq == SEQ_GOT2) && (byte_idx == `LAST_BYTE);

  // Sticky alarm; an edge in the clearing cycle is still blocked and lost
  // RULE17: held until sequence ends
  // RULE18: no new alarm while blocked
  wire alarm_set = mode_any & ~blocked & (|byte_ev);
  always_comb begin
    next_alarm = alarm_set | (alarm_pending & ~seq_done);
    next_source = ({`IN_BYTES{alarm_set}} & byte_ev) | (alarm_source_bytes & ~{`IN_BYTES{seq_done}});
  end

  // Returned byte: frozen inputs or the alarm flag byte
  // RULE8: bit switches only in byte mode
  wire [`BYTE_W-1:0] flag_byte = {`BYTE_W{alarm_pending & mode_byte}} & bit_sel_s;
  wire [`BYTE_W-1:0] read_byte = in_window ? held_in[byte_idx*`BYTE_W +: `BYTE_W] : flag_byte;

  // Sequence, alarm and answer registers
  // The answer byte stays put after the ack, so a slow reader still sees it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq <= SEQ_OPEN;
      alarm_pending <= 1'b0;
      alarm_source_bytes <= '0;
      ack_r <= 1'b0;
      data_r <= '0;
    end else begin
      seq <= next_seq;
      alarm_pending <= next_alarm;
      alarm_source_bytes <= next_source;
      ack_r <= take;
      if (take) data_r <= read_byte;
    end
  end

  // Input image; prev tracks always so blocked edges never fire later
  // Trade-off: the image lags the pins by the two synchroniser flops
  // RULE18: frozen while blocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_in <= '0;
      held_in <= '0;
    end else begin
      prev_in <= live_in;
      if (!blocked) held_in <= live_in;
    end
  end

  // Backplane answer and status straight from registers
  assign inputs_blocked = blocked;
  assign bus.rd_ack = ack_r;
  assign bus.rd_data = data_r;

  // RULE6: only the single selected line
  // RULE7: open-drain pull, shareable
  assign bus.int_line_oe = {`INT_LINES{alarm_pending & mode_line & line_sel_one}} & line_sel_s;
endmodule

// ==== logic/edge_alarm_ctl.sv ====
// Controller end: services the edge alarm and keeps memory copies of the inputs.
// Assumes an APB master on pclk; backplane answers come back on the same clock.
`timescale 1ns/1ps
`include "edge_alarm_defines.svh"

module edge_alarm_ctl #(
  parameter logic [`ADDR_W-1:0] MODULE_BASE = `MODULE_BASE_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic service_active,
  backplane_if.ctl bus
);
  import edge_alarm_pkg::*;

  logic [`CTRL_W-1:0] ctrl;
  logic [`ST_W-1:0] status;
  logic [`ST_W-1:0] mask;
  logic [15:0] word_first;
  logic [15:0] word_second;
  logic [`BYTE_W-1:0] byte_buf [0:`IN_BYTES-1];
  svc_state_t state;
  logic [1:0] idx;
  logic req_r;
  logic slverr_r;

  // Control fields
  wire enable = ctrl[`CTRL_ENABLE];
  wire byte_mode = ctrl[`CTRL_BYTE_MODE];
  wire [1:0] line_idx = ctrl[`CTRL_LINE_MSB:`CTRL_LINE_LSB];
  wire [2:0] bit_idx = ctrl[`CTRL_BIT_MSB:`CTRL_BIT_LSB];
  // RULE3: module must sit above 127
  wire base_ok = (MODULE_BASE >= `MODULE_BASE_MIN);

  // RULE14: line low is a pending level
  wire line_alarm = ~bus.int_line_n[line_idx];
  wire ack = bus.rd_ack;
  wire svc_last = (state == SVC_READ) && ack && (idx == `LAST_BYTE);
  wire poll_hit = (state == SVC_POLL) && ack && bus.rd_data[bit_idx];

  // RULE1: ascending address from the base
  // RULE15: address zero poll, then the words
  assign bus.rd_addr = (state == SVC_POLL) ? `ALARM_BYTE_ADDR : MODULE_BASE + `ADDR_W'(idx);
  assign bus.rd_req = req_r;
  assign service_active = (state == SVC_READ);

  // Service engine: runs to the end once started, nothing preempts it
  // RULE13: uninterruptible service routine
  // RULE4: each byte read once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SVC_IDLE;
      idx <= 2'h0;
      req_r <= 1'b0;
    end else begin
      case (state)
        SVC_IDLE: begin
          idx <= 2'h0;
          if (enable && base_ok && byte_mode) begin
            state <= SVC_POLL;
            req_r <= 1'b1;
          end else if (enable && base_ok && line_alarm) begin
            state <= SVC_READ;
            req_r <= 1'b1;
          end
        end
        SVC_POLL: begin
          if (ack) begin
            state <= poll_hit ? SVC_READ : SVC_IDLE;
            req_r <= poll_hit;
          end
        end
        SVC_READ: begin
          if (ack) begin
            idx <= idx + 2'h1;
            state <= (idx == `LAST_BYTE) ? SVC_IDLE : SVC_READ;
            req_r <= (idx != `LAST_BYTE);
          end
        end
        default: begin
          state <= SVC_IDLE;
          req_r <= 1'b0;
        end
      endcase
    end
  end

  // Byte capture and word copies; first byte is the high half
  // RULE16: software sees only the copies
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `IN_BYTES; i++) byte_buf[i] <= '0;
      word_first <= '0;
      word_second <= '0;
    end else begin
      if ((state == SVC_READ) && ack) byte_buf[idx] <= bus.rd_data;
      if (svc_last) begin
        word_first <= {byte_buf[0], byte_buf[1]};
        word_second <= {byte_buf[2], bus.rd_data};
      end
    end
  end

  // APB decode; zero wait states
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr_ctrl = access & pwrite & (paddr == `REG_CTRL);
  wire wr_mask = access & pwrite & (paddr == `REG_MASK);
  wire rd_status = access & ~pwrite & (paddr == `REG_STATUS);
  wire mapped = (paddr == `REG_CTRL) | (paddr == `REG_STATUS) | (paddr == `REG_MASK) |
                (paddr == `REG_WORD_FIRST) | (paddr == `REG_WORD_SECOND);
  // Seen: poll hit or line low while idle; done: last byte answered
  wire seen_ev = poll_hit | ((state == SVC_IDLE) && enable && line_alarm);
  wire [`ST_W-1:0] st_set = {seen_ev, svc_last};
  wire [31:0] rd_mux = (paddr == `REG_CTRL) ? 32'(ctrl) :
                       (paddr == `REG_STATUS) ? 32'(status) :
                       (paddr == `REG_MASK) ? 32'(mask) :
                       (paddr == `REG_WORD_FIRST) ? 32'(word_first) :
                       (paddr == `REG_WORD_SECOND) ? 32'(word_second) : 32'h0000_0000;

  // Registers; an event in the clearing read stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      mask <= `MASK_RESET;
      status <= `ST_RESET;
      prdata <= 32'h0000_0000;
      slverr_r <= 1'b0;
    end else begin
      if (wr_ctrl) ctrl <= pwdata[`CTRL_W-1:0];
      if (wr_mask) mask <= pwdata[`ST_W-1:0];
      status <= st_set | (status & ~(prdata[`ST_W-1:0] & {`ST_W{rd_status}})); // Only bits already returned
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
        slverr_r <= ~mapped;
      end
    end
  end

  assign pready = 1'b1;
  assign pslverr = access & slverr_r;
  assign irq = |(status & mask);
endmodule

// ==== bench/edge_alarm_assertions.sv ====
// Checker on the backplane between the alarm device end and the controller end.
// Assumes it sits beside the interface and sees only its signals, one clock.
`timescale 1ns/1ps
`include "edge_alarm_defines.svh"

module edge_alarm_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic rd_req,
  input wire logic [`ADDR_W-1:0] rd_addr,
  input wire logic rd_ack,
  input wire logic [`BYTE_W-1:0] rd_data,
  input wire logic [`INT_LINES-1:0] int_line_oe,
  input wire logic [`INT_LINES-1:0] int_line_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Request taken: up and not answered this cycle
  wire take = rd_req && !rd_ack;
  wire in_mod = (rd_addr & 8'hfc) == `MODULE_BASE_DEF;
  logic [1:0] last;

  // Last module byte taken; starts at 3 so byte 0 opens a sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 2'h3;
    end else if (take && in_mod) begin
      last <= rd_addr[1:0];
    end
  end

  a_one_line: assert property ($onehot0(int_line_oe))
    else $error("several interrupt lines pulled");
  a_ack_next: assert property (take && in_mod |=> rd_ack)
    else $error("module byte read not answered next cycle");
  a_ack_pulse: assert property (rd_ack |=> !rd_ack)
    else $error("answer longer than one cycle");
  a_req_hold: assert property (take |=> rd_ack || (rd_req && $stable(rd_addr)))
    else $error("request dropped or moved before answer");
  a_ascending_order: assert property (take && in_mod && rd_addr[1:0] != 2'h0 |-> last == rd_addr[1:0] - 2'h1)
    else $error("module bytes not read in ascending order");
  a_line_release: assert property ($fell(|int_line_oe) |-> last == 2'h3)
    else $error("line released before last byte read");
  a_data_frozen: assert property ($changed(rd_data) |-> rd_ack)
    else $error("read data changed without an answer");
  a_above_image: assert property (take && rd_addr != `ALARM_BYTE_ADDR |-> rd_addr > 8'h7f)
    else $error("module read below the image limit");

  c_seq_end: cover property (take && rd_addr == 8'h83);
  c_line_pull: cover property (|int_line_oe);
  c_poll: cover property (take && rd_addr == `ALARM_BYTE_ADDR);
endmodule

// ==== bench/input_edge_process_alarm_bench.sv ====
// Bench joining the alarm device end and controller end over the backplane.
// Assumes both design ends and the checker are compiled first.
`timescale 1ns/1ps
`include "edge_alarm_defines.svh"

module input_edge_process_alarm_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0, bit_sw = '0;
  logic [31:0] pwdata = '0, din = '0, want = '0, prdata;
  logic pready, pslverr, irq, blocked, pending, svc, j1 = 1, j2 = 0;
  logic [3:0] line_sw = 4'h1, pol = 4'hf, src;
  logic [32:0] exp_q[$];
  int miscompares = 0, n_compared = 0;
  backplane_if bp();

  always #5 pclk = ~pclk;

  edge_alarm_dev edge_alarm_dev_i (.pclk(pclk), .presetn(presetn), .bus(bp), .process_inputs(din),
    .module_base(`MODULE_BASE_DEF), .alarm_path_jumper_first(j1), .alarm_path_jumper_second(j2),
    .interrupt_line_select_switches(line_sw), .alarm_byte_bit_select_switches(bit_sw),
    .edge_polarity_switches(pol), .alarm_pending(pending), .inputs_blocked(blocked), .alarm_source_bytes(src));
  edge_alarm_ctl edge_alarm_ctl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .service_active(svc), .bus(bp));
  edge_alarm_assertions edge_alarm_assertions_i (.pclk(pclk), .presetn(presetn), .rd_req(bp.rd_req),
    .rd_addr(bp.rd_addr), .rd_ack(bp.rd_ack), .rd_data(bp.rd_data), .int_line_oe(bp.int_line_oe),
    .int_line_n(bp.int_line_n));

  task chk(input logic [32:0] s, input logic [32:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask

  task print_verdict;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A used-up wait counts as a mismatch and ends the run
  task give_up(input bit t);
    if (t) begin
      miscompares++;
      print_verdict;
    end
  endtask

  // One APB transfer; a read notes its expected {pslverr, prdata} first
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    give_up(n == 50);
    psel <= 0;
    penable <= 0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0);
  endtask

  task rd(input logic [7:0] a, input logic [32:0] e);
    apb(1'b0, a, 32'h0, e);
  endtask

  // Read results against the oldest note
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front());

  // Pins move after an edge; want mirrors them for expectations
  task poke(input int b, input logic [7:0] v);
    @(posedge pclk);
    din[8*b +: 8] <= v;
    want[8*b +: 8] = v;
  endtask

  // Service done: lower address is the high half of each word
  task serviced(input logic [31:0] v, input logic [3:0] s);
    int n;
    for (n = 0; n < 300 && svc !== 1'b1; n++)
      @(posedge pclk);
    give_up(svc !== 1'b1);
    chk(pending, 1'b1);
    chk(src, s);
    for (n = 0; n < 300 && irq !== 1'b1; n++)
      @(posedge pclk);
    give_up(irq !== 1'b1);
    rd(`REG_WORD_FIRST, {17'h0, v[7:0], v[15:8]});
    rd(`REG_WORD_SECOND, {17'h0, v[23:16], v[31:24]});
    rd(`REG_STATUS, 33'h3);
    @(posedge pclk);
    chk(irq, 1'b0);
    chk({pending, blocked, src}, 6'h0);
  endtask

  initial begin
    int b, k, p;
    logic [7:0] v;
    logic [31:0] hold;
    void'($urandom(30));
    repeat (6) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    // Cleared registers, then an unmapped word is refused
    for (k = 0; k < 5; k++)
      rd(8'(4 * k), 33'h0);
    rd(8'h14, {1'b1, 32'h0});
    // Masked alarm; an edge while blocked must be lost and not change data
    wr(`REG_CTRL, 32'h1);
    poke(0, 8'h5a);
    hold = want;
    for (k = 0; k < 100 && blocked !== 1'b1; k++)
      @(posedge pclk);
    give_up(k == 100);
    poke(0, 8'ha5);
    repeat (40) @(posedge pclk);
    chk(irq, 1'b0);
    rd(`REG_STATUS, 33'h3);
    rd(`REG_WORD_FIRST, {17'h0, hold[7:0], hold[15:8]});
    wr(`REG_MASK, 32'h1);
    repeat (20) @(posedge pclk);
    rd(`REG_STATUS, 33'h0);
    // Every line, each byte in both polarities, wrong edge first
    for (p = 0; p < 2; p++) begin
      pol <= p ? 4'b1010 : 4'b0101;
      for (b = 0; b < 4; b++) begin
        line_sw <= 4'h1 << b;
        wr(`REG_CTRL, 32'h1 | (b << 2));
        poke(b, pol[b] ? 8'h00 : 8'hff);
        repeat (10) @(posedge pclk);
        rd(`REG_STATUS, 33'h0);
        v = 8'($urandom);
        poke(b, pol[b] ? (v | 8'h01) : ((v | 8'h40) & 8'hfe));
        serviced(want, 4'h1 << b);
      end
    end
    // Alarm byte path on a random bit, lines left alone
    j2 <= 1;
    line_sw <= 4'h0;
    for (k = 0; k < 2; k++) begin
      p = $urandom_range(7);
      bit_sw <= 8'h01 << p;
      wr(`REG_CTRL, 32'h3 | (p << 8));
      poke(1, 8'h00);
      poke(1, 8'($urandom) | 8'h01);
      repeat (5) @(posedge pclk);
      chk(bp.int_line_n, 4'hf);
      serviced(want, 4'h2);
    end
    // Two lines selected, then no valid jumper pair: nothing reaches a line
    // Leave byte mode first so no poll waits on a module that stops answering
    wr(`REG_CTRL, 32'h1);
    repeat (10) @(posedge pclk);
    j2 <= 0;
    line_sw <= 4'h3;
    for (k = 0; k < 2; k++) begin
      poke(1, 8'h00);
      poke(1, 8'hff);
      repeat (20) @(posedge pclk);
      chk(bp.int_line_n, 4'hf);
      chk(pending, 1'b1);
      rd(`REG_STATUS, 33'h0);
      j1 <= 0;
      j2 <= 1;
      line_sw <= 4'h1;
    end
    // Reset mid-run; inputs held high give fresh edges after reset, serviced once enabled
    presetn <= 0;
    j1 <= 1;
    j2 <= 0;
    line_sw <= 4'h1;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    wr(`REG_MASK, 32'h1);
    wr(`REG_CTRL, 32'h1);
    serviced(want, 4'ha);
    print_verdict;
  end
endmodule
